// *** xsw_consts.svh ***
`ifndef XSW_CONSTS_SVH
`define XSW_CONSTS_SVH

// wake source vector bit positions
`define XSW_SRC_IRQ0 0
`define XSW_SRC_IRQ1 1
`define XSW_SRC_IRQ2 2
`define XSW_SRC_IRQ4 3
`define XSW_SRC_IRQ5 4
`define XSW_SRC_PORT0 5
`define XSW_SRC_BTMR 6
`define XSW_SRC_USB 7
`define XSW_SRC_IR 8
`define XSW_NUM_SRC 9

// oscillator restart settle time, nanoseconds, and its cycle count at 100 MHz
`define XSW_CLK_PERIOD_NS 10
`define XSW_SETTLE_NS 200
`define XSW_SETTLE_CYC ((`XSW_SETTLE_NS + `XSW_CLK_PERIOD_NS - 1) / `XSW_CLK_PERIOD_NS)

`endif

// *** xsw_pkg.sv ***
package xsw_pkg;
  typedef enum logic [3:0]
  {
    XSW_RUN = 4'b0001,
    XSW_HOLD = 4'b0010,
    XSW_RESUME = 4'b0100,
    XSW_RESET = 4'b1000
  } xsw_state_type;
endpackage : xsw_pkg

// *** xsw_wake_detect.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "xsw_consts.svh"
module xsw_wake_detect
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ext_irq_zero,
  input wire logic ext_irq_one,
  input wire logic ext_irq_two,
  input wire logic ext_irq_four,
  input wire logic ext_irq_five,
  input wire logic port0_irq,
  input wire logic base_timer_irq,
  input wire logic usb_bus_active_irq,
  input wire logic ir_rx_irq,
  output logic [`XSW_NUM_SRC-1:0] wake_src,
  output logic wake_any
);
  typedef struct packed
  {
    logic [`XSW_NUM_SRC-1:0] src_ff;
  } xsw_wd_state_type;
  xsw_wd_state_type st_ff;
  xsw_wd_state_type nxt_st;
  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.src_ff[`XSW_SRC_IRQ0] = ext_irq_zero;
    nxt_st.src_ff[`XSW_SRC_IRQ1] = ext_irq_one;
    nxt_st.src_ff[`XSW_SRC_IRQ2] = ext_irq_two;
    nxt_st.src_ff[`XSW_SRC_IRQ4] = ext_irq_four;
    nxt_st.src_ff[`XSW_SRC_IRQ5] = ext_irq_five;
    nxt_st.src_ff[`XSW_SRC_PORT0] = port0_irq;
    nxt_st.src_ff[`XSW_SRC_BTMR] = base_timer_irq;
    nxt_st.src_ff[`XSW_SRC_USB] = usb_bus_active_irq;
    nxt_st.src_ff[`XSW_SRC_IR] = ir_rx_irq;
  end
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      st_ff <= '0;
    else
      st_ff <= nxt_st;
  end
  assign wake_src = st_ff.src_ff;
  assign wake_any = |st_ff.src_ff;
endmodule : xsw_wake_detect
`default_nettype wire

// *** xsw_standby_ctrl.sv ***
// Behaviour
// - standby halts cpu and peripherals, timer/ir stay
// - entry stops pll, ceramic and rc oscillators
// - crystal keeps its running state on entry
// - low external clear pin releases standby
// - watchdog reset releases standby
// - external irq zero/one/two/four/five release standby
// - port 0 interrupt releases standby
// - base timer interrupt releases standby
// - usb bus activity interrupt releases standby
// - infrared receiver interrupt releases standby
`timescale 1ns/1ns
`default_nettype none
`include "xsw_consts.svh"
module xsw_standby_ctrl
#(
  parameter int SETTLE_CYC = `XSW_SETTLE_CYC
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic standby_req,
  input wire logic xtal_run_req,
  input wire logic external_clear_pin_n,
  input wire logic wdt_reset,
  input wire logic ext_irq_zero,
  input wire logic ext_irq_one,
  input wire logic ext_irq_two,
  input wire logic ext_irq_four,
  input wire logic ext_irq_five,
  input wire logic port0_irq,
  input wire logic base_timer_irq,
  input wire logic usb_bus_active_irq,
  input wire logic ir_rx_irq,
  output xsw_pkg::xsw_state_type state,
  output logic cpu_halt,
  output logic periph_halt,
  output logic base_timer_run,
  output logic ir_rx_run,
  output logic pll_run,
  output logic ceramic_oscillator_run,
  output logic rc_osc_run,
  output logic xtal_osc_run,
  output logic sys_reset_req,
  output logic resume_pulse,
  output logic [`XSW_NUM_SRC-1:0] wake_cause
);
  import xsw_pkg::*;

  localparam logic [7:0] SETTLE_LAST = 8'(SETTLE_CYC - 1);

  // last settle cycle; shared by the state machine and its checks
  function automatic logic settle_done(input logic [7:0] cnt);
    settle_done = (cnt == SETTLE_LAST);
  endfunction : settle_done

  typedef struct packed
  {
    xsw_state_type fsm_ff;
    logic xtal_ff;
    logic [7:0] cnt_ff;
    logic resume_ff;
    logic [`XSW_NUM_SRC-1:0] cause_ff;
  } xsw_ctrl_state_type;

  xsw_ctrl_state_type st_ff;
  xsw_ctrl_state_type nxt_st;
  logic [`XSW_NUM_SRC-1:0] wake_src;
  logic wake_any;
  logic reset_src;

  xsw_wake_detect u_wake
  (
    .clk(clk),
    .rst_n(rst_n),
    .ext_irq_zero(ext_irq_zero),
    .ext_irq_one(ext_irq_one),
    .ext_irq_two(ext_irq_two),
    .ext_irq_four(ext_irq_four),
    .ext_irq_five(ext_irq_five),
    .port0_irq(port0_irq),
    .base_timer_irq(base_timer_irq),
    .usb_bus_active_irq(usb_bus_active_irq),
    .ir_rx_irq(ir_rx_irq),
    .wake_src(wake_src),
    .wake_any(wake_any)
  );

  // reset sources beat interrupts; reset sources act from any state, interrupts only from hold
  assign reset_src = !external_clear_pin_n || wdt_reset;

  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.resume_ff = 1'b0;
    case (st_ff.fsm_ff)
      XSW_RUN:
      begin
        nxt_st.xtal_ff = xtal_run_req;
        if (reset_src)
          nxt_st.fsm_ff = XSW_RESET;
        else if (standby_req)
        begin
          // crystal state frozen as it is at entry
          nxt_st.fsm_ff = XSW_HOLD;
          nxt_st.cause_ff = '0;
        end
      end
      XSW_HOLD:
      begin
        if (reset_src)
          nxt_st.fsm_ff = XSW_RESET;
        else if (wake_any)
        begin
          nxt_st.fsm_ff = XSW_RESUME;
          nxt_st.cause_ff = wake_src;
          nxt_st.cnt_ff = '0;
        end
      end
      XSW_RESUME:
      begin
        // oscillators restart, cpu waits for them to settle
        if (reset_src)
          nxt_st.fsm_ff = XSW_RESET;
        else if (settle_done(st_ff.cnt_ff))
        begin
          nxt_st.fsm_ff = XSW_RUN;
          nxt_st.resume_ff = 1'b1;
        end
        else
          nxt_st.cnt_ff = st_ff.cnt_ff + 8'h01;
      end
      XSW_RESET:
      begin
        // held until both reset sources drop; normal reset sequence follows
        nxt_st.xtal_ff = xtal_run_req;
        if (!reset_src)
          nxt_st.fsm_ff = XSW_RUN;
      end
      default:
        nxt_st.fsm_ff = XSW_RESET;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      st_ff.fsm_ff <= XSW_RUN;
      st_ff.xtal_ff <= 1'b0;
      st_ff.cnt_ff <= 8'h00;
      st_ff.resume_ff <= 1'b0;
      st_ff.cause_ff <= '0;
    end
    else
      st_ff <= nxt_st;
  end

  logic in_hold;
  assign in_hold = (st_ff.fsm_ff == XSW_HOLD);
  assign state = st_ff.fsm_ff;
  assign cpu_halt = (st_ff.fsm_ff != XSW_RUN);
  assign periph_halt = in_hold || (st_ff.fsm_ff == XSW_RESET);
  assign base_timer_run = (st_ff.fsm_ff != XSW_RESET);
  assign ir_rx_run = (st_ff.fsm_ff != XSW_RESET);
  assign pll_run = !in_hold;
  assign ceramic_oscillator_run = !in_hold;
  assign rc_osc_run = !in_hold;
  // in hold the oscillator follows the latched entry state, not the request
  assign xtal_osc_run = in_hold ? st_ff.xtal_ff : xtal_run_req;
  assign sys_reset_req = (st_ff.fsm_ff == XSW_RESET);
  assign resume_pulse = st_ff.resume_ff;
  assign wake_cause = st_ff.cause_ff;

  // hold entry and stay
  a_hold_stops_osc: assert property (
    @(posedge clk) disable iff (!rst_n)
    in_hold |-> !pll_run && !ceramic_oscillator_run && !rc_osc_run && cpu_halt)
    else $error("oscillator running in hold");
  a_xtal_kept: assert property (
    @(posedge clk) disable iff (!rst_n)
    $rose(in_hold) |-> xtal_osc_run == $past(xtal_run_req))
    else $error("crystal state changed at entry");
  a_xtal_steady: assert property (
    @(posedge clk) disable iff (!rst_n)
    in_hold && $past(in_hold) |-> $stable(xtal_osc_run))
    else $error("crystal state moved during hold");
  a_timer_ir_run: assert property (
    @(posedge clk) disable iff (!rst_n)
    in_hold |-> base_timer_run && ir_rx_run && periph_halt)
    else $error("timer or ir halted in hold");
  a_entry_from_run: assert property (
    @(posedge clk) disable iff (!rst_n)
    $rose(in_hold) |-> $past(state) == XSW_RUN && $past(standby_req) && !$past(reset_src))
    else $error("hold entered without a request");
  a_hold_waits: assert property (
    @(posedge clk) disable iff (!rst_n)
    in_hold && !reset_src && !wake_any |=> in_hold)
    else $error("hold left with no release source");
  a_state_onehot: assert property (
    @(posedge clk) disable iff (!rst_n)
    $onehot(state))
    else $error("state code not one-hot");
  a_run_no_halt: assert property (
    @(posedge clk) disable iff (!rst_n)
    state == XSW_RUN |-> !cpu_halt && !periph_halt && pll_run)
    else $error("core halted while running");

  // reset sources win from any state
  a_clear_pin_exit: assert property (
    @(posedge clk) disable iff (!rst_n)
    in_hold && !external_clear_pin_n |=> sys_reset_req)
    else $error("clear pin did not release hold");
  a_wdt_exit: assert property (
    @(posedge clk) disable iff (!rst_n)
    in_hold && wdt_reset |=> sys_reset_req && pll_run)
    else $error("watchdog did not release hold");
  a_reset_any: assert property (
    @(posedge clk) disable iff (!rst_n)
    reset_src |=> sys_reset_req)
    else $error("reset source did not reach reset state");
  a_reset_leaves: assert property (
    @(posedge clk) disable iff (!rst_n)
    sys_reset_req && !reset_src |=> state == XSW_RUN && !cpu_halt)
    else $error("reset state not left after sources dropped");

  // a source already pending would wake first, so each exit check starts from a quiet hold
  a_irq_exit: assert property (
    @(posedge clk) disable iff (!rst_n)
    in_hold && !reset_src && !wake_any && ext_irq_two ##1 !reset_src |=> state == XSW_RESUME)
    else $error("ext irq did not release hold");
  a_irq_zero_exit: assert property (
    @(posedge clk) disable iff (!rst_n)
    in_hold && !reset_src && !wake_any && ext_irq_zero ##1 !reset_src
      |=> wake_cause[`XSW_SRC_IRQ0])
    else $error("ext irq zero did not release hold");
  a_irq_one_exit: assert property (
    @(posedge clk) disable iff (!rst_n)
    in_hold && !reset_src && !wake_any && ext_irq_one ##1 !reset_src
      |=> wake_cause[`XSW_SRC_IRQ1])
    else $error("ext irq one did not release hold");
  a_irq_four_exit: assert property (
    @(posedge clk) disable iff (!rst_n)
    in_hold && !reset_src && !wake_any && ext_irq_four ##1 !reset_src
      |=> wake_cause[`XSW_SRC_IRQ4])
    else $error("ext irq four did not release hold");
  a_irq_five_exit: assert property (
    @(posedge clk) disable iff (!rst_n)
    in_hold && !reset_src && !wake_any && ext_irq_five ##1 !reset_src
      |=> wake_cause[`XSW_SRC_IRQ5])
    else $error("ext irq five did not release hold");
  a_port0_exit: assert property (
    @(posedge clk) disable iff (!rst_n)
    in_hold && !reset_src && !wake_any && port0_irq ##1 !reset_src |=> !in_hold)
    else $error("port 0 did not release hold");
  a_btmr_exit: assert property (
    @(posedge clk) disable iff (!rst_n)
    in_hold && !reset_src && !wake_any && base_timer_irq ##1 !reset_src
      |=> wake_cause[`XSW_SRC_BTMR])
    else $error("base timer did not release hold");
  a_usb_exit: assert property (
    @(posedge clk) disable iff (!rst_n)
    in_hold && !reset_src && !wake_any && usb_bus_active_irq ##1 !reset_src |=> !in_hold)
    else $error("usb activity did not release hold");
  a_ir_exit: assert property (
    @(posedge clk) disable iff (!rst_n)
    in_hold && !reset_src && !wake_any && ir_rx_irq ##1 !reset_src |=> !in_hold)
    else $error("ir receiver did not release hold");
  a_cause_snapshot: assert property (
    @(posedge clk) disable iff (!rst_n)
    in_hold && wake_any && !reset_src |=> wake_cause == $past(wake_src))
    else $error("wake cause not captured at release");
  a_cause_held: assert property (
    @(posedge clk) disable iff (!rst_n)
    !in_hold && !(state == XSW_RUN && standby_req && !reset_src) |=> $stable(wake_cause))
    else $error("wake cause changed outside entry or release");

  // settle length is tracked by the counter, not by a long repetition
  a_osc_restart: assert property (
    @(posedge clk) disable iff (!rst_n)
    in_hold && wake_any && !reset_src
      |=> state == XSW_RESUME && pll_run && ceramic_oscillator_run && rc_osc_run)
    else $error("oscillators not restarted on release");
  a_resume_entry: assert property (
    @(posedge clk) disable iff (!rst_n)
    $rose(state == XSW_RESUME) |-> st_ff.cnt_ff == 8'h00)
    else $error("settle count not cleared on release");
  a_settle_bound: assert property (
    @(posedge clk) disable iff (!rst_n)
    state == XSW_RESUME |-> st_ff.cnt_ff <= SETTLE_LAST)
    else $error("settle count past its end");
  a_settle_step: assert property (
    @(posedge clk) disable iff (!rst_n)
    state == XSW_RESUME && !reset_src && !settle_done(st_ff.cnt_ff)
      |=> state == XSW_RESUME && st_ff.cnt_ff == $past(st_ff.cnt_ff) + 8'h01)
    else $error("settle count did not advance");
  a_resume_done: assert property (
    @(posedge clk) disable iff (!rst_n)
    state == XSW_RESUME && !reset_src && settle_done(st_ff.cnt_ff)
      |=> state == XSW_RUN && resume_pulse)
    else $error("resume not completed after settle");
  a_resume_awake: assert property (
    @(posedge clk) disable iff (!rst_n)
    state == XSW_RESUME |-> cpu_halt && !periph_halt && pll_run)
    else $error("oscillators or peripherals off while settling");
  a_pulse_once: assert property (
    @(posedge clk) disable iff (!rst_n)
    resume_pulse |=> !resume_pulse)
    else $error("resume pulse longer than one cycle");
  a_pulse_cause: assert property (
    @(posedge clk) disable iff (!rst_n)
    resume_pulse |-> $past(state) == XSW_RESUME)
    else $error("resume pulse without settle");
endmodule : xsw_standby_ctrl
`default_nettype wire

// *** xsw_cpu_model.sv ***
`timescale 1ns/1ns
`default_nettype none
module xsw_cpu_model
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic sleep_cmd,
  input wire logic [8:0] wake_cmd,
  input wire logic cpu_halt,
  output logic standby_req,
  output logic [8:0] irq_lvl
);
  // sources hold their level until the core runs again, so every pin acts as a level irq
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      standby_req <= 1'h0;
      irq_lvl <= 9'h000;
    end
    else
    begin
      standby_req <= sleep_cmd | (standby_req & ~cpu_halt);
      irq_lvl <= wake_cmd | (irq_lvl & {9{cpu_halt}});
    end
  end
endmodule : xsw_cpu_model
`default_nettype wire

// *** tb_crystal_standby_wake_control.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "xsw_consts.svh"
module tb_crystal_standby_wake_control;
  import xsw_pkg::*;
  logic clk = 1'h0;
  logic rst_n = 1'h0;
  logic sleep_cmd = 1'h0;
  logic [8:0] wake_cmd = 9'h000;
  logic xtal_run_req = 1'h0;
  logic clr_n = 1'h1;
  logic wdt_reset = 1'h0;
  logic standby_req, cpu_halt, periph_halt, base_timer_run, ir_rx_run, pll_run;
  logic ceramic_oscillator_run, rc_osc_run, xtal_osc_run, sys_reset_req, resume_pulse;
  logic [8:0] irq, wake_cause;
  xsw_state_type state;
  int errors = 0;
  int checks_done = 0;
  int cycles = 0;
  always #5 clk = ~clk;
  xsw_cpu_model xsw_cpu_model_i (.clk(clk), .rst_n(rst_n), .sleep_cmd(sleep_cmd),
    .wake_cmd(wake_cmd), .cpu_halt(cpu_halt), .standby_req(standby_req), .irq_lvl(irq));
  xsw_standby_ctrl #(.SETTLE_CYC(2)) xsw_standby_ctrl_i (.clk(clk), .rst_n(rst_n),
    .standby_req(standby_req), .xtal_run_req(xtal_run_req), .external_clear_pin_n(clr_n),
    .wdt_reset(wdt_reset), .ext_irq_zero(irq[`XSW_SRC_IRQ0]), .ext_irq_one(irq[`XSW_SRC_IRQ1]),
    .ext_irq_two(irq[`XSW_SRC_IRQ2]), .ext_irq_four(irq[`XSW_SRC_IRQ4]),
    .ext_irq_five(irq[`XSW_SRC_IRQ5]), .port0_irq(irq[`XSW_SRC_PORT0]),
    .base_timer_irq(irq[`XSW_SRC_BTMR]), .usb_bus_active_irq(irq[`XSW_SRC_USB]),
    .ir_rx_irq(irq[`XSW_SRC_IR]), .state(state), .cpu_halt(cpu_halt),
    .periph_halt(periph_halt), .base_timer_run(base_timer_run), .ir_rx_run(ir_rx_run),
    .pll_run(pll_run), .ceramic_oscillator_run(ceramic_oscillator_run),
    .rc_osc_run(rc_osc_run), .xtal_osc_run(xtal_osc_run), .sys_reset_req(sys_reset_req),
    .resume_pulse(resume_pulse), .wake_cause(wake_cause));
  task finish_test;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : finish_test
  task chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task wait_state(input xsw_state_type s);
    int n;
    n = 0;
    while (state !== s && n < 40)
    begin
      @(negedge clk);
      n++;
    end
    chk(state, s);
  endtask : wait_state
  // crystal request flips once inside standby; the latched value must not follow it
  task go_hold(input logic x);
    @(posedge clk);
    sleep_cmd <= 1'h1;
    xtal_run_req <= x;
    @(posedge clk);
    sleep_cmd <= 1'h0;
    wait_state(XSW_HOLD);
    @(posedge clk);
    xtal_run_req <= ~x;
    @(negedge clk);
    chk({cpu_halt, periph_halt, base_timer_run, ir_rx_run}, 4'hf);
    chk({pll_run, ceramic_oscillator_run, rc_osc_run}, 3'h0);
    chk(xtal_osc_run, x);
    chk(wake_cause, 9'h000);
  endtask : go_hold
  task wake_one(input int i);
    go_hold(i[0]);
    @(posedge clk);
    wake_cmd <= 9'h001 << i;
    @(posedge clk);
    wake_cmd <= 9'h000;
    wait_state(XSW_RUN);
    chk(resume_pulse, 1'h1);
    chk(wake_cause, 9'h001 << i);
    chk(pll_run, 1'h1);
  endtask : wake_one
  // every irq fires together with the reset source; the reset must win
  task reset_src(input logic wd);
    go_hold(1'h1);
    @(posedge clk);
    clr_n <= wd;
    wdt_reset <= wd;
    wake_cmd <= 9'h1ff;
    @(posedge clk);
    wake_cmd <= 9'h000;
    wait_state(XSW_RESET);
    chk(sys_reset_req, 1'h1);
    @(posedge clk);
    clr_n <= 1'h1;
    wdt_reset <= 1'h0;
    wait_state(XSW_RUN);
    chk(sys_reset_req, 1'h0);
  endtask : reset_src
  task irq_in_run;
    @(posedge clk);
    wake_cmd <= 9'h1ff;
    @(posedge clk);
    wake_cmd <= 9'h000;
    repeat (4) @(negedge clk);
    chk(state, XSW_RUN);
  endtask : irq_in_run
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 3000)
    begin
      errors++;
      finish_test();
    end
  end
  initial
  begin
    repeat (2) @(posedge clk);
    rst_n <= 1'h1;
    @(negedge clk);
    chk(state, XSW_RUN);
    chk({cpu_halt, sys_reset_req, pll_run, ceramic_oscillator_run, rc_osc_run}, 5'h07);
    chk(wake_cause, 9'h000);
    irq_in_run();
    for (int i = 0; i < `XSW_NUM_SRC; i++)
      wake_one(i);
    reset_src(1'h0);
    reset_src(1'h1);
    finish_test();
  end
endmodule : tb_crystal_standby_wake_control
`default_nettype wire
